// ### pkg/delta_sigma_pkg.sv
/*
 * Shared constants for the one-bit delta-sigma link: input scaling,
 * clipping thresholds, marker period and link clock timing.
 * Assumes a 10 MHz system clock on both ends of the link.
 */
package delta_sigma_pkg;

    // Analog input carried as signed microvolts
    localparam int VIN_W = 20;
    localparam int ACC_W = 22;
    // Clipping voltage, 312.5 mV
    localparam logic signed [ACC_W-1:0] CLIP_UV = 22'sh4c4b4;
    // Full linear input, 250 mV
    localparam logic signed [ACC_W-1:0] LINEAR_UV = 22'sh3d090;
    // Ones density at zero, plus and minus full linear input, percent
    localparam int DENSITY_ZERO_PCT = 50;
    localparam int DENSITY_POS_PCT = 90;
    localparam int DENSITY_NEG_PCT = 10;
    // One opposite bit per this many clocks while clipped
    localparam int MARKER_PERIOD = 128;
    localparam int MARKER_W = $clog2(MARKER_PERIOD);

    // System clock and link clock timing
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
    localparam int MOD_CLK_TYP_HZ = 20_000_000;
    localparam int LINK_PERIOD_NS = 800;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / 2 / SYS_PERIOD_NS;
    // Cycles from a pin change until the synchroniser output shows it
    localparam int SYNC_LAT = 2;

    // Decimation filter settings
    localparam int SINC_ORDER = 3;
    localparam int SINC_OSR = 256;
    localparam int SINC_DIFF_DELAY = 1;
    localparam int MIN_OSR_SINC3 = 110;
    localparam int MIN_OSR_SINC2 = 200;
    // Upper OSR bound at the typical clock and least output rate
    localparam int MAX_OSR = 285;

endpackage : delta_sigma_pkg

// ### pkg/delta_sigma_link_if.sv
/*
 * Link between the modulator end and the decimating filter end:
 * the modulator clock driven by the filter end, and the bit stream.
 * Assumes the testbench joins both ends through one instance.
 */
`timescale 1ns/1ps

interface delta_sigma_link_if;
    logic modulator_clock;
    logic bit_data;

    // Modulator end: takes the clock, drives the stream
    modport modulator
    (
        input modulator_clock,
        output bit_data
    );

    // Filter end: makes the clock, reads the stream
    modport filter
    (
        output modulator_clock,
        input bit_data
    );
endinterface : delta_sigma_link_if

// ### src/bitstream_modulator.sv
/*
 * Modulator end of the delta-sigma link. A first-order accumulator
 * turns a signed microvolt input into a one-bit stream, advanced on
 * each falling edge of the supplied modulator clock.
 *
 * Input scaling: the input is offset by the clipping voltage so the
 * accumulator works on 0 to twice the clipping voltage. Each new bit
 * adds the offset input to the carried error; a one is sent and the
 * span subtracted when the sum reaches the span. The long-run ones
 * density is therefore exact for any constant linear input.
 *
 * Clipping: at or beyond the clipping voltage the stream is constant,
 * except that the last bit of every marker period has the opposite
 * value so the far end can tell a live modulator from a dead wire.
 * The marker counter restarts whenever the input returns to the
 * linear range, and the accumulator is parked at mid scale so the
 * first linear bits do not carry a stale error.
 *
 * Status: clip_out follows the range of the last bit sent,
 * nonlinear_out flags inputs beyond the full linear range one cycle
 * after they appear, bit_strobe_out pulses as each new bit is shown.
 *
 * Assumes the modulator clock is slow enough to be sampled by clk_in
 * through two flip-flops, at least four system cycles per half period.
 * Assumes vin_uv_in comes from logic on the clk_in domain.
 * Assumes rst_in is synchronous to clk_in and held at least one edge.
 * Limitation: an input that moves mid period is taken as it stands
 * two cycles after the falling edge, when the synchronised fall is seen; no averaging within a period is done.
 */
`timescale 1ns/1ps

module bitstream_modulator
    import delta_sigma_pkg::*;
(
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link toward the filter end
    delta_sigma_link_if.modulator link,
    // Analog input, signed microvolts, same clock domain
    input wire logic signed [delta_sigma_pkg::VIN_W-1:0] vin_uv_in,
    // Status
    output logic clip_out,
    output logic nonlinear_out,
    output logic bit_strobe_out
);
    import delta_sigma_pkg::*;

    typedef enum {
        RANGE_LINEAR,
        RANGE_CLIP_LOW,
        RANGE_CLIP_HIGH
    } range_t;

    typedef struct packed {
        logic clk_sync1;
        logic clk_sync2;
        logic clk_prev;
        logic signed [ACC_W-1:0] acc;
        logic [MARKER_W-1:0] marker_cnt;
        logic bit_data;
        logic clip;
        logic nonlinear;
        logic strobe;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic signed [ACC_W-1:0] vin_wide;
    logic signed [ACC_W-1:0] offset;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] span;
    logic fall_seen;
    range_t range_sel;

    // Classify the input against the clipping thresholds
    function automatic range_t classify(
        input logic signed [ACC_W-1:0] v
    );
        range_t r;
        r = RANGE_LINEAR;
        if (v >= CLIP_UV)
        begin
            r = RANGE_CLIP_HIGH;
        end
        else if (v <= -CLIP_UV)
        begin
            r = RANGE_CLIP_LOW;
        end
        return r;
    endfunction : classify

    // Magnitude test for the full linear range, strictly beyond it
    function automatic logic beyond(
        input logic signed [ACC_W-1:0] v,
        input logic signed [ACC_W-1:0] lim
    );
        return (v > lim) || (v < -lim);
    endfunction : beyond

    // Input scaling: shift the range so the accumulator sees 0 to span
    always_comb
    begin
        vin_wide = ACC_W'(vin_uv_in);
        span = CLIP_UV + CLIP_UV;
        offset = vin_wide + CLIP_UV;
        sum = state_reg.acc + offset;
        range_sel = classify(vin_wide);
        // Edge found after the two synchroniser stages only
        fall_seen = state_reg.clk_prev && !state_reg.clk_sync2;
    end

    // Next state: one output bit per falling modulator clock edge
    always_comb
    begin
        state_next = state_reg;
        // Two synchroniser stages on the link clock; the edge detector
        // reads only the second stage, never the metastable first one
        state_next.clk_sync1 = link.modulator_clock;
        state_next.clk_sync2 = state_reg.clk_sync1;
        state_next.clk_prev = state_reg.clk_sync2;
        state_next.strobe = 1'b0;
        // Linear-range flag, registered so the output comes from a flop
        state_next.nonlinear = beyond(vin_wide, LINEAR_UV);
        if (fall_seen)
        begin
            state_next.strobe = 1'b1;
            case (range_sel)
                RANGE_LINEAR:
                begin
                    // Error feedback keeps the long-run density exact
                    state_next.clip = 1'b0;
                    state_next.marker_cnt = '0;
                    if (sum >= span)
                    begin
                        state_next.bit_data = 1'b1;
                        state_next.acc = sum - span;
                    end
                    else
                    begin
                        state_next.bit_data = 1'b0;
                        state_next.acc = sum;
                    end
                end
                RANGE_CLIP_LOW, RANGE_CLIP_HIGH:
                begin
                    state_next.clip = 1'b1;
                    state_next.marker_cnt = state_reg.marker_cnt + 1'b1;
                    // Last count of the period sends the marker bit
                    if (state_reg.marker_cnt ==
                        MARKER_W'(MARKER_PERIOD - 1))
                    begin
                        state_next.bit_data =
                            (range_sel == RANGE_CLIP_LOW);
                    end
                    else
                    begin
                        state_next.bit_data =
                            (range_sel == RANGE_CLIP_HIGH);
                    end
                    // Start from mid scale when the input returns
                    state_next.acc = CLIP_UV;
                end
                default:
                begin
                    // Unreachable; keep the stream low if ever taken
                    state_next.bit_data = 1'b0;
                end
            endcase
        end
    end

    // State register; reset parks the stream low and unclipped
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    // The marker counter wraps by itself at the end of each period
    assign link.bit_data = state_reg.bit_data;
    assign clip_out = state_reg.clip;
    assign nonlinear_out = state_reg.nonlinear;
    assign bit_strobe_out = state_reg.strobe;

endmodule : bitstream_modulator

// ### src/sinc_decimator.sv
/*
 * Filter end of the delta-sigma link. Makes the modulator clock by
 * dividing clk_in, samples the stream at each rising edge, and runs
 * a sinc decimator: ORDER accumulators, keep every OSR-th (at most every MAX_OSR-th), ORDER combs.
 * Assumes the modulator end changes data on the falling clock edge.
 */
`timescale 1ns/1ps

module sinc_decimator
    import delta_sigma_pkg::*;
#(
    parameter int ORDER = delta_sigma_pkg::SINC_ORDER,
    parameter int OSR = delta_sigma_pkg::SINC_OSR,
    parameter int DIFF_DELAY = delta_sigma_pkg::SINC_DIFF_DELAY,
    parameter int HALF_CYCLES = delta_sigma_pkg::LINK_HALF_CYCLES
)
(
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link toward the modulator end
    delta_sigma_link_if.filter link,
    // Decimated result
    output logic [ORDER*$clog2(OSR*DIFF_DELAY):0] sample_out,
    output logic sample_valid_out
);
    import delta_sigma_pkg::*;

    // OSR held to the bound that keeps the output rate sufficient
    localparam int EFF_OSR = (OSR > MAX_OSR) ? MAX_OSR : OSR;
    localparam int W = ORDER * $clog2(OSR * DIFF_DELAY) + 1;
    localparam int PH_W = $clog2(2 * HALF_CYCLES);
    localparam int DEC_W = $clog2(EFF_OSR + 1);

    typedef struct packed {
        logic [PH_W-1:0] phase;
        logic mod_clk;
        logic data_sync1;
        logic data_sync2;
        logic [DEC_W-1:0] dec_cnt;
        logic [ORDER-1:0][W-1:0] integ;
        logic [ORDER-1:0][DIFF_DELAY-1:0][W-1:0] comb_dly;
        logic [W-1:0] sample;
        logic valid;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [W-1:0] stage;

    // Clock divider, sampling, integrators at bit rate, combs at R
    always_comb
    begin
        state_next = state_reg;
        stage = '0;
        state_next.valid = 1'b0;
        state_next.data_sync1 = link.bit_data;
        state_next.data_sync2 = state_reg.data_sync1;
        // Divider: high for the first half, rising at phase zero
        if (state_reg.phase == PH_W'(2 * HALF_CYCLES - 1))
        begin
            state_next.phase = '0;
        end
        else
        begin
            state_next.phase = state_reg.phase + 1'b1;
        end
        state_next.mod_clk = (state_next.phase < PH_W'(HALF_CYCLES));
        // Sampling skewed by the synchroniser so the bit seen is the
        // pin level at the rising edge, one cycle after the data change
        if (state_reg.phase == PH_W'(SYNC_LAT))
        begin
            stage = W'(state_reg.data_sync2);
            for (int k = 0; k < ORDER; k++)
            begin
                stage = state_reg.integ[k] + stage;
                state_next.integ[k] = stage;
            end
            if (state_reg.dec_cnt == DEC_W'(EFF_OSR - 1))
            begin
                state_next.dec_cnt = '0;
                for (int k = 0; k < ORDER; k++)
                begin
                    state_next.comb_dly[k][0] = stage;
                    for (int d = 1; d < DIFF_DELAY; d++)
                    begin
                        state_next.comb_dly[k][d] =
                            state_reg.comb_dly[k][d-1];
                    end
                    stage = stage - state_reg.comb_dly[k][DIFF_DELAY-1];
                end
                state_next.sample = stage;
                state_next.valid = 1'b1;
            end
            else
            begin
                state_next.dec_cnt = state_reg.dec_cnt + 1'b1;
            end
        end
    end

    // State register; clock starts low, filter history cleared
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign link.modulator_clock = state_reg.mod_clk;
    assign sample_out = state_reg.sample;
    assign sample_valid_out = state_reg.valid;

endmodule : sinc_decimator

// ### verif/delta_sigma_link_asserts.sv
/*
 * Concurrent checks on the link wires: clock shape and bit timing.
 * Assumes the filter end divides by the default HALF_CYCLES of 4.
 */
`timescale 1ns/1ps

module delta_sigma_link_asserts
(
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link wires
    input wire logic modulator_clock,
    input wire logic bit_data
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // Clock shape; the first high phase after reset is one cycle short
    a_clk_low_half: assert property (
        $fell(modulator_clock) |-> !modulator_clock [*4] ##1 modulator_clock)
        else $error("link clock low phase wrong");
    a_clk_high_half: assert property (
        $rose(modulator_clock) && !$past(rst_in, 2)
            |-> modulator_clock [*4] ##1 !modulator_clock)
        else $error("link clock high phase wrong");
    a_clk_full_period: assert property (
        $rose(modulator_clock) && !$past(rst_in, 2)
            |-> ##8 $rose(modulator_clock))
        else $error("link clock period wrong");
    a_clk_after_reset: assert property (
        $fell(rst_in) |-> !modulator_clock ##1 modulator_clock)
        else $error("link clock not started after reset");
    // Bits move three edges after the fall, then hold a whole period
    a_data_after_fall: assert property (
        $changed(bit_data)
            |-> $past(modulator_clock, 4) && !$past(modulator_clock, 3))
        else $error("bit changed away from clock fall");
    a_data_one_per: assert property (
        $changed(bit_data) |=> $stable(bit_data) [*7])
        else $error("more than one bit per period");
    // Filter samples at the rise, so data must be quiet while high
    a_data_held_high: assert property (
        modulator_clock && $past(modulator_clock) |-> $stable(bit_data))
        else $error("bit moved while link clock high");
endmodule : delta_sigma_link_asserts

// ### verif/delta_sigma_bitstream_link_tb.sv
/*
 * Bench joining modulator and decimator, checked against integer
 * models of both ends. Assumes OSR 8 in the filter to keep runs short.
 */
`timescale 1ns/1ps

module delta_sigma_bitstream_link_tb;
    import delta_sigma_pkg::*;
    localparam int OSR_TB = 8;
    localparam int SW = SINC_ORDER * $clog2(OSR_TB) + 1;
    localparam int CLIP = int'(CLIP_UV);
    localparam int LIN = int'(LINEAR_UV);
    logic clk_in;
    logic rst_in;
    logic signed [VIN_W-1:0] vin_uv;
    logic clip;
    logic nonlinear;
    logic strobe;
    logic [SW-1:0] sample;
    logic sample_valid;
    logic mc_prev;
    logic [31:0] seed;
    int bad_count, checks_done, cycles, o;
    int acc, mark_cnt, i1, i2, i3, p1, p2, p3, c, nb;
    int exp_q[$];

    delta_sigma_link_if link();
    bitstream_modulator u_bitstream_modulator (.clk_in(clk_in),
        .rst_in(rst_in), .link(link), .vin_uv_in(vin_uv),
        .clip_out(clip), .nonlinear_out(nonlinear), .bit_strobe_out(strobe));
    sinc_decimator #(.OSR(OSR_TB)) u_sinc_decimator (.clk_in(clk_in),
        .rst_in(rst_in), .link(link), .sample_out(sample),
        .sample_valid_out(sample_valid));
    delta_sigma_link_asserts u_delta_sigma_link_asserts (.clk_in(clk_in),
        .rst_in(rst_in), .modulator_clock(link.modulator_clock),
        .bit_data(link.bit_data));

    // Clock
    initial
    begin
        clk_in = 1'b0;
        forever #(SYS_PERIOD_NS / 2) clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // Ideal first-order loop; clipped bits carry a marker every 128
    task automatic model_bit();
        int v;
        logic b;
        logic cl;
        v = int'(vin_uv);
        cl = v >= CLIP || v <= -CLIP;
        if (cl)
        begin
            b = (v > 0) ^ (mark_cnt == MARKER_PERIOD - 1);
            mark_cnt = (mark_cnt + 1) % MARKER_PERIOD;
            acc = CLIP;
        end
        else
        begin
            acc = acc + v + CLIP;
            b = acc >= 2 * CLIP;
            if (b)
                acc = acc - 2 * CLIP;
            mark_cnt = 0;
        end
        check(32'(link.bit_data), 32'(b));
        check(32'(clip), 32'(cl));
        check(32'(nonlinear), 32'(v > LIN || v < -LIN));
    endtask : model_bit

    // Chained integrators per bit, combs once per OSR bits
    task automatic filter_bit(input int x);
        int t;
        i1 += x;
        i2 += i1;
        i3 += i2;
        nb++;
        if (nb == OSR_TB)
        begin
            nb = 0;
            c = i3 - p1;
            p1 = i3;
            t = c - p2;
            p2 = c;
            c = t - p3;
            p3 = t;
            exp_q.push_back(c & ((1 << SW) - 1));
        end
    endtask : filter_bit

    // Models follow the design edge by edge; reset clears both
    always @(posedge clk_in)
    begin
        mc_prev <= link.modulator_clock;
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            final_report();
        end
        else if (rst_in)
        begin
            {acc, mark_cnt, i1, i2, i3, p1, p2, p3, nb} = '0;
            exp_q.delete();
        end
        else
        begin
            if (strobe === 1'b1)
                model_bit();
            if (link.modulator_clock === 1'b1 && mc_prev === 1'b0)
                filter_bit(int'(link.bit_data));
            if (sample_valid === 1'b1)
                check(32'(sample), exp_q.size() ? exp_q.pop_front() : -1);
        end
    end

    task automatic next_bit();
        do
            @(posedge clk_in);
        while (strobe !== 1'b1);
    endtask : next_bit

    // Applies v from one bit boundary and counts the ones of n bits
    task automatic run_bits(input int v, input int n, output int ones);
        next_bit();
        vin_uv <= v[VIN_W-1:0];
        ones = 0;
        repeat (n)
        begin
            next_bit();
            ones += int'(link.bit_data);
        end
        $display("test vin %0d over %0d bits done", v, n);
    endtask : run_bits

    initial
    begin
        rst_in = 1'b1;
        vin_uv = '0;
        seed = 32'hb96adfce;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        run_bits(0, 128, o);
        check(o, DENSITY_ZERO_PCT * 128 / 100);
        run_bits(LIN, 100, o);
        check(o, DENSITY_POS_PCT);
        run_bits(-LIN, 100, o);
        check(o, DENSITY_NEG_PCT);
        run_bits(CLIP, 2 * MARKER_PERIOD, o);
        check(o, 2 * MARKER_PERIOD - 2);
        run_bits(-CLIP, 2 * MARKER_PERIOD, o);
        check(o, 2);
        repeat (150)
        begin
            seed = lfsr(seed);
            run_bits(int'(signed'(seed[VIN_W-1:0])), 2, o);
        end
        rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        check({30'h0, link.modulator_clock, link.bit_data}, 32'h0);
        rst_in <= 1'b0;
        run_bits(0, 64, o);
        check(o, 32);
        final_report();
    end
endmodule : delta_sigma_bitstream_link_tb
